// >>> hdl/ipcb2_top.sv
// Pending-clear word for interrupts 32..59 behind an AHB-Lite slave
`timescale 1ns/10ps
`include "ipcb2_map.svh"
module ipcb2_top
   import ipcb2_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic [31:0] i_irq_set,
   input  wire logic [31:0] i_irq_active,
   output logic [31:0]      o_irq_pending
);
   typedef struct packed {
      ipcb2_phase_t                phase;
      logic                        wr;
      logic [`IPCB2_ADDR_BITS-1:0] addr;
      ipcb2_word_t                 rdata;
      ipcb2_word_t                 pend;
      logic                        ready;
      logic                        resp;
   } ipcb2_state_t;

   ipcb2_state_t                st_q;
   ipcb2_state_t                st_d;
   ipcb2_word_t                 pend_bits;
   ipcb2_word_t                 clr_bits;
   logic                        addr_ok;
   logic                        data_ok;
   logic                        data_wr;
   logic [`IPCB2_ADDR_BITS-1:0] addr_lo;

   // A transfer starts only on an active address phase seen with hready high
   function automatic logic ipcb2_xfer(
      input logic       sel,
      input logic       rdy,
      input logic [1:0] trans
   );
      logic busy;
      busy = (trans == `IPCB2_HTRANS_NONSEQ) || (trans == `IPCB2_HTRANS_SEQ);
      return sel && rdy && busy;
   endfunction

   // Register decode used by both phases
   function automatic logic ipcb2_hit(
      input logic [`IPCB2_ADDR_BITS-1:0] a
   );
      return a == `IPCB2_OFS_PEND_CLR;
   endfunction

   // Read-only view of the in-service lines, for debug
   function automatic logic ipcb2_svc_hit(
      input logic [`IPCB2_ADDR_BITS-1:0] a
   );
      return a == `IPCB2_OFS_IN_SERVICE;
   endfunction

   // Holes in the word never show or take a one
   function automatic ipcb2_word_t ipcb2_impl(
      input ipcb2_word_t w
   );
      return w & `IPCB2_IMPL_MASK;
   endfunction

   // Read data chosen at the address phase; unmapped offsets read zero
   function automatic ipcb2_word_t ipcb2_read_word(
      input logic [`IPCB2_ADDR_BITS-1:0] a,
      input ipcb2_word_t                 pend,
      input ipcb2_word_t                 act
   );
      ipcb2_word_t w;
      w = '0;
      if (ipcb2_hit(a)) begin
         w = ipcb2_impl(pend);
      end else if (ipcb2_svc_hit(a)) begin
         w = ipcb2_impl(act);
      end
      return w;
   endfunction

   assign addr_lo = i_haddr[`IPCB2_ADDR_BITS-1:0];
   assign addr_ok = ipcb2_xfer(i_hsel, i_hready, i_htrans);

   // An unknown phase code is treated as no data phase at all
   always_comb begin
      data_ok = 1'b0;
      unique case (st_q.phase)
         IPCB2_IDLE: begin
            data_ok = 1'b0;
         end
         IPCB2_DATA: begin
            data_ok = 1'b1;
         end
         default: begin
            data_ok = 1'b0;
         end
      endcase
   end

   assign data_wr = data_ok && st_q.wr && ipcb2_hit(st_q.addr);

   always_comb begin
      clr_bits = '0;
      // only ones written in a write data phase clear
      if (data_wr) begin
         clr_bits = ipcb2_impl(i_hwdata);
      end
   end

   // Each implemented bit owns one flag; the service guard sits in the flag
   genvar g;
   generate
      for (g = `IPCB2_FLD_TOP_LO; g <= `IPCB2_FLD_TOP_HI; g++) begin : g_fld_top
         ipcb2_pend_bit u_bit (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_set        (i_irq_set[g]),
            .i_clr        (clr_bits[g]),
            .i_in_service (i_irq_active[g]),
            .o_pend       (pend_bits[g])
         );
      end

      for (g = `IPCB2_FLD_MID_LO; g <= `IPCB2_FLD_MID_HI; g++) begin : g_fld_mid
         ipcb2_pend_bit u_bit (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_set        (i_irq_set[g]),
            .i_clr        (clr_bits[g]),
            .i_in_service (i_irq_active[g]),
            .o_pend       (pend_bits[g])
         );
      end

      for (g = `IPCB2_FLD_LOW_LO; g <= `IPCB2_FLD_LOW_HI; g++) begin : g_fld_low
         ipcb2_pend_bit u_bit (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_set        (i_irq_set[g]),
            .i_clr        (clr_bits[g]),
            .i_in_service (i_irq_active[g]),
            .o_pend       (pend_bits[g])
         );
      end

      // holes carry no flag and read zero
      for (g = 0; g < `IPCB2_WORD_BITS; g++) begin : g_hole
         if (((`IPCB2_IMPL_MASK >> g) & 32'h1) == 32'h0) begin : g_zero
            assign pend_bits[g] = 1'b0;
         end
      end
   endgenerate

   always_comb begin
      st_d       = st_q;
      st_d.pend  = pend_bits;
      st_d.phase = IPCB2_IDLE;
      st_d.rdata = '0;
      st_d.ready = `IPCB2_READY_RESET;
      st_d.resp  = `IPCB2_HRESP_OKAY;
      if (addr_ok) begin
         st_d.phase = IPCB2_DATA;
         st_d.wr    = i_hwrite;
         st_d.addr  = addr_lo;
         // Read data is taken here so hrdata can come from a flop
         if (!i_hwrite) begin
            st_d.rdata = ipcb2_read_word(addr_lo, pend_bits, i_irq_active);
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         st_q.phase <= IPCB2_IDLE;
         st_q.wr    <= 1'b0;
         st_q.addr  <= '0;
         st_q.rdata <= '0;
         st_q.pend  <= `IPCB2_PEND_RESET;
         st_q.ready <= `IPCB2_READY_RESET;
         st_q.resp  <= `IPCB2_HRESP_OKAY;
      end else begin
         st_q <= st_d;
      end
   end

   // Zero-wait slave; a read right after a write sees the flags before that clear
   assign o_hreadyout   = st_q.ready;
   assign o_hresp       = st_q.resp;
   assign o_hrdata      = st_q.rdata;
   assign o_irq_pending = st_q.pend;
endmodule

// >>> shared/ipcb2_map.svh
// Address map, field layout and constants of the pending-clear word
`ifndef IPCB2_MAP_SVH
`define IPCB2_MAP_SVH
`define IPCB2_OFS_PEND_CLR   12'h000
`define IPCB2_OFS_IN_SERVICE 12'h004
`define IPCB2_ADDR_BITS      12
`define IPCB2_IMPL_MASK      32'h0CFF_FFEF
`define IPCB2_PEND_RESET     32'h0000_0000
`define IPCB2_FIRST_IRQ      32
`define IPCB2_HTRANS_NONSEQ  2'h2
`define IPCB2_HTRANS_SEQ     2'h3
`define IPCB2_HRESP_OKAY     1'h0
`define IPCB2_READY_RESET    1'h1
`define IPCB2_WORD_BITS      32
`define IPCB2_FLD_TOP_HI     27
`define IPCB2_FLD_TOP_LO     26
`define IPCB2_FLD_MID_HI     23
`define IPCB2_FLD_MID_LO     5
`define IPCB2_FLD_LOW_HI     3
`define IPCB2_FLD_LOW_LO     0
`endif

// >>> shared/ipcb2_pkg.sv
// Types shared by the pending-clear word design
package ipcb2_pkg;
   typedef logic [31:0] ipcb2_word_t;
   typedef enum logic [1:0] {
      IPCB2_IDLE  = 2'b01,
      IPCB2_DATA  = 2'b10
   } ipcb2_phase_t;
endpackage

// >>> hdl/ipcb2_pend_bit.sv
// One pending flag: source set, software clear, service guard
`timescale 1ns/10ps
module ipcb2_pend_bit (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   input  wire logic i_set,
   input  wire logic i_clr,
   input  wire logic i_in_service,
   output logic      o_pend
);
   typedef struct packed {
      logic pend;
   } ipcb2_bit_state_t;

   ipcb2_bit_state_t st_q;
   ipcb2_bit_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (i_clr && !i_in_service) begin
         st_d.pend = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (i_set) begin
         st_d.pend = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_pend = st_q.pend;
endmodule

// >>> testbench/ipcb2_top_props.sv
// Checker of the pending-clear word at the top ports
`timescale 1ns/10ps
module ipcb2_top_props (
   input wire logic        i_sys_clk, i_rst_b, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp,
   input wire logic [1:0]  i_htrans,
   input wire logic [31:0] i_haddr, i_hwdata, o_hrdata, i_irq_set, i_irq_active, o_irq_pending
);
   logic        wr_q, rd_q, rda_q;
   logic [31:0] clr_q, set_q;
   wire         acc = i_hsel & i_hready & i_htrans[1] & i_rst_b;
   wire         at0 = i_haddr[11:0] == 12'h000;
   // Clear mask as seen at the data phase edge
   always_ff @(posedge i_sys_clk) begin
      wr_q  <= acc & i_hwrite & at0;
      rd_q  <= acc & !i_hwrite & at0;
      rda_q <= acc & !i_hwrite;
      clr_q <= wr_q ? i_hwdata & ~i_irq_active : 32'h0;
      set_q <= i_irq_set;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bad response");
   pend_reserved_a: assert property ((o_irq_pending & 32'hF300_0010) == 0) else $error("res set");
   rdata_reserved_a: assert property ((o_hrdata & 32'hF300_0010) == 0) else $error("res read");
   set_maps_a: assert property ((($past(i_irq_set, 2) & 32'h0CFF_FFEF) & ~o_irq_pending) == 0)
      else $error("set lost");
   clear_takes_a: assert property ((o_irq_pending & $past(clr_q) & ~$past(set_q)) == 0)
      else $error("clear lost");
   no_stray_clear_a: assert property ((($past(o_irq_pending) & ~o_irq_pending) & ~$past(clr_q)) == 0)
      else $error("stray clear");
   read_view_a: assert property (rd_q |-> o_hrdata == o_irq_pending) else $error("read");
   rdata_idle_a: assert property (!rda_q |-> o_hrdata == 0) else $error("rdata idle");
endmodule
bind ipcb2_top ipcb2_top_props ipcb2_top_props_inst (.*);

// >>> testbench/test_irq_pending_clear_bank2.sv
// Bench for the pending-clear word over its bus port
`timescale 1ns/10ps
module test_irq_pending_clear_bank2;
   logic        i_sys_clk = 0, i_rst_b = 0, i_hsel = 0, i_hwrite = 0;
   logic [1:0]  i_htrans = 0;
   logic [2:0]  i_hsize = 3'h2;
   logic [31:0] i_haddr = 0, i_hwdata = 0, i_irq_set = 0, i_irq_active = 0, rd;
   wire         i_hready, o_hreadyout, o_hresp;
   wire  [31:0] o_hrdata, o_irq_pending;
   int          miscompares = 0, n_tests = 0;
   assign i_hready = o_hreadyout;
   ipcb2_top ipcb2_top_inst (.*);
   initial forever #4 i_sys_clk = ~i_sys_clk;
   task automatic end_sim;
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   // Hready and read data taken at the rising edge that ends the phase
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (i_hready !== 1'h1 && n < 50);
      rd = o_hrdata;
      if (n >= 50) begin
         miscompares++;
         end_sim();
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_hsel <= 1;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= {20'h0, a};
      wait_rdy();
      i_htrans <= 2'h0;
      i_hwdata <= d;
      wait_rdy();
      // Read data is chosen at the address phase, so a clear needs one edge to show
      if (w) @(posedge i_sys_clk);
      if (!w) chk(rd, d);
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rst_b <= 1;
      i_irq_set <= 32'hFFFF_FFFF;
      @(posedge i_sys_clk);
      i_irq_set <= 32'h0;
      i_irq_active <= 32'h0000_000F;
      xfer(0, 12'h000, 32'h0CFF_FFEF);
      xfer(1, 12'h000, 32'h0C00_0000);
      xfer(0, 12'h000, 32'h00FF_FFEF);
      xfer(1, 12'h000, 32'h00F0_0020);
      xfer(0, 12'h000, 32'h000F_FFCF);
      xfer(1, 12'h000, 32'h0);
      xfer(0, 12'h000, 32'h000F_FFCF);
      xfer(1, 12'h000, 32'hFFFF_FFFF);
      xfer(0, 12'h000, 32'h0000_000F);
      xfer(0, 12'h004, 32'h0000_000F);
      i_irq_active <= 32'h0;
      xfer(1, 12'h000, 32'hFFFF_FFFF);
      xfer(0, 12'h000, 32'h0);
      xfer(0, 12'h010, 32'h0);
      end_sim();
   end
endmodule
